// ---- core/smp_pkg.sv ----
// Constants and types shared by the stepper move profiler
package smp_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int NS_PER_S = 1_000_000_000;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = TICK_NS / (NS_PER_S / CLK_HZ);
    localparam int DEC_SCALE = 2000;
    localparam int SPD_W = 21;
    localparam logic [20:0] START_MIN = 21'h000001;
    localparam logic [20:0] START_MAX = 21'h1E847F;
    localparam logic [12:0] JERK_MAX = 13'h1388;
    localparam logic [12:0] JERK_LIN = 13'h0000;
    localparam logic [12:0] JERK_TRI = 13'h0001;
    localparam logic [15:0] JINC_TRI = 16'h0001;
    localparam logic [23:0] TGT_MAX = 24'h7FFFFF;
    localparam logic [23:0] TGT_BAD = 24'h800000;
    // Register byte offsets
    localparam logic [5:0] A_CTRL = 6'h00;
    localparam logic [5:0] A_TARGET = 6'h04;
    localparam logic [5:0] A_SPEED = 6'h08;
    localparam logic [5:0] A_START = 6'h0C;
    localparam logic [5:0] A_ACCEL = 6'h10;
    localparam logic [5:0] A_DECEL = 6'h14;
    localparam logic [5:0] A_JERK = 6'h18;
    localparam logic [5:0] A_STATUS = 6'h1C;
    localparam logic [5:0] A_POS = 6'h20;
    localparam logic [5:0] A_VNOW = 6'h24;
    // Control bits
    localparam int C_START = 0, C_ISTOP = 1, C_HOLD = 2, C_RESUME = 3;
    localparam int C_CLR = 4, C_JOG = 5, C_TYPE = 8;
    // Status bits
    localparam int S_BUSY = 0, S_HOLD = 1, S_PINV = 2, S_FCW = 3;
    localparam int S_FCCW = 4, S_PERR = 5, S_DECEL = 6, S_DIR = 7;
    // Synchronised pin bits
    localparam int P_STOPJOG = 0, P_CW = 1, P_CCW = 2, P_ESTOP = 3;
    // Move types
    localparam logic [2:0] MV_REL = 3'h0;
    localparam logic [2:0] MV_ABS = 3'h1;
    localparam logic [2:0] MV_JOG = 3'h2;
    localparam logic [2:0] MV_REG = 3'h3;
    localparam logic [2:0] MV_HOME = 3'h4;

    typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RUN, ST_HELD} smp_state_t;

    typedef struct packed {
        smp_state_t st;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] pinPrev;
        logic rdValid;
        logic [31:0] rdata;
        logic istop;
        logic jogRun;
        logic [2:0] reqType;
        logic [2:0] mvType;
        logic resume;
        logic [23:0] target;
        logic [20:0] speed;
        logic [20:0] startSpd;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [12:0] jerk;
        logic dir;
        logic inf;
        logic stopping;
        logic holdReq;
        logic decelPh;
        logic [23:0] remain;
        logic [20:0] vNow;
        logic [20:0] rampVel;
        logic [15:0] accNow;
        logic [31:0] tickCnt;
        logic posInvalid;
        logic faultCw;
        logic faultCcw;
        logic profErr;
        logic power;
        logic [31:0] position;
    } smp_reg_t;

    localparam smp_reg_t RST_REG = '0;
endpackage

// ---- core/smp_step_timer.sv ----
// Step rate generator: one step pulse per rate-th of a second
`timescale 1ns/100ps
module smp_step_timer #(
    parameter int RATE_W = 21
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic enable,
    input wire logic [RATE_W-1:0] rate,
    output logic stepPulse
);
    typedef struct packed {
        logic [24:0] acc;
        logic pulse;
    } smp_timer_t;

    localparam logic [24:0] FULL = 25'(smp_pkg::CLK_HZ);

    smp_timer_t r;
    smp_timer_t next_r;
    logic [24:0] sum;

    always_comb begin
        next_r = r;
        next_r.pulse = 1'b0;
        sum = r.acc + 25'(rate);
        if (!enable) begin
            next_r.acc = 25'h0000000;
        end else if (sum >= FULL) begin
            next_r.acc = sum - FULL;
            next_r.pulse = 1'b1;
        end else begin
            next_r.acc = sum;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r <= '0;
        end else if (clkEn) begin
            r <= next_r;
        end
    end

    assign stepPulse = r.pulse;
endmodule

// ---- core/smp_move_profiler.sv ----
// Move profile generator and stop handler with Avalon-MM registers
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module smp_move_profiler #(
    parameter int TICK_CYC = smp_pkg::TICK_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic stopJogIn,
    input wire logic cwLimitIn,
    input wire logic ccwLimitIn,
    input wire logic estopIn,
    output logic stepPulse,
    output logic stepDir,
    output logic motorPower
);
    smp_pkg::smp_reg_t r;
    smp_pkg::smp_reg_t next_r;
    logic [3:0] rise;
    logic tick;
    logic timerPulse;
    logic [41:0] vSq;
    logic [41:0] vsSq;
    logic [63:0] brakeRoom;
    localparam logic [63:0] BRAKE_K = 64'(longint'(smp_pkg::DEC_SCALE)
        * smp_pkg::TICK_CYC / TICK_CYC);
    logic brake;
    logic cmdStart;
    logic cmdHold;
    logic cmdResume;
    logic cmdClr;
    logic istopCmd;
    logic immStop;
    logic limitHit;
    logic exempt;
    logic jogLike;
    logic [15:0] jInc;
    logic [20:0] gap;
    logic [21:0] sumV;
    logic [31:0] tgt32;
    logic [31:0] absDist;
    logic dirCw;
    logic calcDir;
    logic paramOk;
    logic bad;

    // Status word assembly
    function automatic logic [31:0] statusWord(
        input smp_pkg::smp_reg_t s
    );
        logic [31:0] d;
        d = 32'h00000000;
        d[smp_pkg::S_BUSY] = (s.st == smp_pkg::ST_RUN)
            || (s.st == smp_pkg::ST_CALC);
        d[smp_pkg::S_HOLD] = (s.st == smp_pkg::ST_HELD);
        d[smp_pkg::S_PINV] = s.posInvalid;
        d[smp_pkg::S_FCW] = s.faultCw;
        d[smp_pkg::S_FCCW] = s.faultCcw;
        d[smp_pkg::S_PERR] = s.profErr;
        d[smp_pkg::S_DECEL] = s.decelPh | s.stopping;
        d[smp_pkg::S_DIR] = s.dir;
        return d;
    endfunction

    // Read data decode
    function automatic logic [31:0] rdMux(
        input smp_pkg::smp_reg_t s,
        input logic [5:0] a
    );
        logic [31:0] d;
        d = 32'h00000000;
        case (a)
            smp_pkg::A_CTRL: begin
                d[smp_pkg::C_ISTOP] = s.istop;
                d[smp_pkg::C_JOG] = s.jogRun;
                d[smp_pkg::C_TYPE +: 3] = s.reqType;
            end
            smp_pkg::A_TARGET: d[23:0] = s.target;
            smp_pkg::A_SPEED: d[20:0] = s.speed;
            smp_pkg::A_START: d[20:0] = s.startSpd;
            smp_pkg::A_ACCEL: d[15:0] = s.accel;
            smp_pkg::A_DECEL: d[15:0] = s.decel;
            smp_pkg::A_JERK: d[12:0] = s.jerk;
            smp_pkg::A_STATUS: d = statusWord(s);
            smp_pkg::A_POS: d = s.position;
            smp_pkg::A_VNOW: d[20:0] = s.vNow;
            default: d = 32'h00000000;
        endcase
        return d;
    endfunction

    smp_step_timer #(
        .RATE_W(smp_pkg::SPD_W)
    ) u_timer (
        .core_clk(core_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .enable(r.st == smp_pkg::ST_RUN),
        .rate(r.vNow),
        .stepPulse(timerPulse)
    );

    assign rise = r.sync2 & ~r.pinPrev;
    assign tick = (r.tickCnt == 32'(TICK_CYC - 1));
    assign vSq = 42'(r.vNow) * 42'(r.vNow);
    assign vsSq = 42'(r.startSpd) * 42'(r.startSpd);
    assign brakeRoom = 64'(r.remain) * 64'(r.decel) * BRAKE_K;
    assign brake = brakeRoom <= 64'(vSq - vsSq);
    assign gap = r.speed - r.vNow;
    assign jInc = (r.jerk == smp_pkg::JERK_TRI) ? smp_pkg::JINC_TRI
        : 16'(r.jerk);
    assign tgt32 = {{8{r.target[23]}}, r.target};
    assign absDist = ($signed(tgt32) > $signed(r.position))
        ? tgt32 - r.position : r.position - tgt32;
    assign jogLike = (r.mvType == smp_pkg::MV_JOG)
        || (r.mvType == smp_pkg::MV_REG);
    assign exempt = jogLike || (r.mvType == smp_pkg::MV_HOME);
    assign dirCw = (r.reqType == smp_pkg::MV_ABS)
        ? ($signed(tgt32) > $signed(r.position)) : !r.target[23];
    assign calcDir = r.resume ? r.dir : dirCw;
    assign paramOk = (r.startSpd >= smp_pkg::START_MIN)
        && (r.startSpd <= smp_pkg::START_MAX)
        && (r.speed >= r.startSpd)
        && (r.accel != 16'h0000)
        && (r.decel != 16'h0000)
        && (r.jerk <= smp_pkg::JERK_MAX);
    assign bad = (calcDir ? r.faultCw : r.faultCcw)
        || (!r.resume && (r.reqType == smp_pkg::MV_ABS)
        && (r.posInvalid || (absDist > 32'(smp_pkg::TGT_MAX))))
        || (!r.resume && (r.reqType == smp_pkg::MV_REL)
        && (r.target == smp_pkg::TGT_BAD));

    always_comb begin
        next_r = r;
        cmdStart = 1'b0;
        cmdHold = 1'b0;
        cmdResume = 1'b0;
        cmdClr = 1'b0;
        istopCmd = 1'b0;
        sumV = 22'h000000;
        next_r.rdValid = 1'b0;
        next_r.power = 1'b1;
        next_r.sync1 = {estopIn, ccwLimitIn, cwLimitIn, stopJogIn};
        next_r.sync2 = r.sync1;
        next_r.pinPrev = r.sync2;
        next_r.tickCnt = tick ? 32'h00000000 : r.tickCnt + 32'h00000001;

        // Register reads answer one cycle after the request
        if (read && !r.rdValid) begin
            next_r.rdValid = 1'b1;
            next_r.rdata = rdMux(r, address);
        end

        if (write) begin
            case (address)
                smp_pkg::A_CTRL: begin
                    cmdStart = writedata[smp_pkg::C_START];
                    cmdHold = writedata[smp_pkg::C_HOLD];
                    cmdResume = writedata[smp_pkg::C_RESUME];
                    cmdClr = writedata[smp_pkg::C_CLR];
                    istopCmd = writedata[smp_pkg::C_ISTOP] & ~r.istop;
                    next_r.istop = writedata[smp_pkg::C_ISTOP];
                    next_r.jogRun = writedata[smp_pkg::C_JOG];
                    next_r.reqType = writedata[smp_pkg::C_TYPE +: 3];
                end
                smp_pkg::A_TARGET: next_r.target = writedata[23:0];
                smp_pkg::A_SPEED: next_r.speed = writedata[20:0];
                smp_pkg::A_START: next_r.startSpd = writedata[20:0];
                smp_pkg::A_ACCEL: next_r.accel = writedata[15:0];
                smp_pkg::A_DECEL: next_r.decel = writedata[15:0];
                smp_pkg::A_JERK: next_r.jerk = writedata[12:0];
                smp_pkg::A_POS: begin
                    next_r.position = writedata;
                    next_r.posInvalid = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Clears first so that a same-cycle fault still sets
        if (cmdClr) begin
            next_r.faultCw = 1'b0;
            next_r.faultCcw = 1'b0;
            next_r.profErr = 1'b0;
        end

        // Position follows every step issued
        if (timerPulse) begin
            next_r.position = r.dir ? r.position + 32'h00000001
                : r.position - 32'h00000001;
        end

        case (r.st)
            smp_pkg::ST_IDLE: begin
                if (cmdStart) begin
                    next_r.st = smp_pkg::ST_CALC;
                    next_r.resume = 1'b0;
                end
            end
            smp_pkg::ST_CALC: begin
                next_r.st = smp_pkg::ST_RUN;
                next_r.vNow = r.startSpd;
                next_r.accNow = 16'h0000;
                next_r.rampVel = 21'h000000;
                next_r.decelPh = 1'b0;
                next_r.stopping = 1'b0;
                next_r.holdReq = 1'b0;
                next_r.tickCnt = 32'h00000000;
                if (!r.resume) begin
                    next_r.mvType = r.reqType;
                    next_r.dir = dirCw;
                    next_r.inf = (r.reqType != smp_pkg::MV_REL)
                        && (r.reqType != smp_pkg::MV_ABS);
                    if (r.reqType == smp_pkg::MV_ABS) begin
                        next_r.remain = absDist[23:0];
                    end else begin
                        next_r.remain = r.target[23] ? 24'h0 - r.target
                            : r.target;
                    end
                end
                if (!paramOk || bad) begin
                    next_r.st = smp_pkg::ST_IDLE;
                    next_r.profErr = 1'b1;
                end else if (!next_r.inf && next_r.remain == 24'h0) begin
                    next_r.st = smp_pkg::ST_IDLE;
                end
            end
            smp_pkg::ST_RUN: begin
                if (timerPulse && !r.inf) begin
                    next_r.remain = r.remain - 24'h000001;
                end
                if (!r.inf && brake) begin
                    next_r.decelPh = 1'b1;
                end
                if (tick) begin
                    if (r.stopping || r.decelPh) begin
                        if ({1'b0, r.vNow} > {1'b0, r.startSpd}
                            + 22'(r.decel)) begin
                            next_r.vNow = r.vNow - 21'(r.decel);
                        end else begin
                            next_r.vNow = r.startSpd;
                        end
                    end else if (r.vNow < r.speed) begin
                        if (r.jerk == smp_pkg::JERK_LIN) begin
                            next_r.accNow = r.accel;
                        end else if (gap <= r.rampVel) begin
                            next_r.accNow = (r.accNow > jInc)
                                ? r.accNow - jInc : jInc;
                        end else if (r.accNow < r.accel) begin
                            next_r.accNow = ({1'b0, r.accNow}
                                + {1'b0, jInc} > {1'b0, r.accel})
                                ? r.accel : r.accNow + jInc;
                            next_r.rampVel = r.rampVel
                                + 21'(next_r.accNow);
                        end
                        sumV = {1'b0, r.vNow} + 22'(next_r.accNow);
                        next_r.vNow = (sumV >= {1'b0, r.speed})
                            ? r.speed : sumV[20:0];
                    end
                end
                if (jogLike && (rise[smp_pkg::P_STOPJOG] || !r.jogRun)) begin
                    next_r.stopping = 1'b1;
                end
                if (cmdHold) begin
                    next_r.stopping = 1'b1;
                    next_r.holdReq = (r.mvType == smp_pkg::MV_REL)
                        || (r.mvType == smp_pkg::MV_ABS);
                end
                if (r.stopping && (r.vNow == r.startSpd)) begin
                    next_r.st = r.holdReq ? smp_pkg::ST_HELD
                        : smp_pkg::ST_IDLE;
                end
                if (!r.inf && timerPulse && (r.remain == 24'h000001)) begin
                    next_r.st = smp_pkg::ST_IDLE;
                end
            end
            smp_pkg::ST_HELD: begin
                if (cmdStart) begin
                    next_r.st = smp_pkg::ST_CALC;
                    next_r.resume = 1'b0;
                end else if (cmdResume) begin
                    next_r.st = smp_pkg::ST_CALC;
                    next_r.resume = 1'b1;
                end
            end
            default: next_r.st = smp_pkg::ST_IDLE;
        endcase

        // Limits met in the travel direction block that direction
        if (r.st == smp_pkg::ST_RUN) begin
            if (rise[smp_pkg::P_CW] && r.dir) begin
                next_r.faultCw = 1'b1;
            end
            if (rise[smp_pkg::P_CCW] && !r.dir) begin
                next_r.faultCcw = 1'b1;
            end
        end
        limitHit = (r.st == smp_pkg::ST_RUN) && !exempt
            && (rise[smp_pkg::P_CW] || rise[smp_pkg::P_CCW]);
        immStop = istopCmd || rise[smp_pkg::P_ESTOP] || limitHit;

        // Immediate stop overrides everything; a held move is dropped too
        if (immStop && (r.st != smp_pkg::ST_IDLE)) begin
            next_r.st = smp_pkg::ST_IDLE;
            next_r.stopping = 1'b0;
            next_r.holdReq = 1'b0;
            if (r.st == smp_pkg::ST_RUN) begin
                next_r.posInvalid = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r <= smp_pkg::RST_REG;
        end else if (clkEn) begin
            r <= next_r;
        end
    end

    assign readdata = r.rdata;
    assign waitrequest = read & ~r.rdValid;
    assign stepPulse = timerPulse;
    assign stepDir = r.dir;
    assign motorPower = r.power;
endmodule

// ---- testbench/smp_move_checker.sv ----
// Concurrent checks on the move profiler ports
`timescale 1ns/100ps
module smp_move_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [5:0] address,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic cwLimitIn,
    input wire logic ccwLimitIn,
    input wire logic estopIn,
    input wire logic stepPulse,
    input wire logic stepDir,
    input wire logic motorPower
);
    logic istopLast;
    logic tgtNeg;
    logic startDir;
    logic [2:0] moveType;
    logic ctrlWr;
    logic posMove;
    logic dirMove;
    assign ctrlWr = write && address == smp_pkg::A_CTRL;
    assign posMove = moveType == smp_pkg::MV_REL
        || moveType == smp_pkg::MV_ABS;
    assign dirMove = moveType == smp_pkg::MV_REL
        || moveType == smp_pkg::MV_JOG;
    // Shadow of the last command fields written by the host
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            istopLast <= 1'b0;
            tgtNeg <= 1'b0;
            startDir <= 1'b0;
            moveType <= 3'h7;
        end else begin
            if (write && address == smp_pkg::A_TARGET) begin
                tgtNeg <= writedata[23];
            end
            if (ctrlWr) begin
                istopLast <= writedata[smp_pkg::C_ISTOP];
            end
            if (ctrlWr && writedata[smp_pkg::C_START]) begin
                moveType <= writedata[10:8];
                startDir <= ~tgtNeg;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_power;
        motorPower |=> motorPower;
    endproperty
    a_power: assert property (p_power)
        else $error("motor power dropped");
    property p_estop;
        $rose(estopIn) |-> ##8 (!stepPulse) [*8];
    endproperty
    a_estop: assert property (p_estop)
        else $error("steps after emergency stop");
    property p_istop;
        ctrlWr && writedata[smp_pkg::C_ISTOP] && !istopLast
            |-> ##3 (!stepPulse) [*8];
    endproperty
    a_istop: assert property (p_istop)
        else $error("steps after host stop");
    property p_cw_limit;
        $rose(cwLimitIn) && posMove |-> ##8 (!stepPulse) [*8];
    endproperty
    a_cw_limit: assert property (p_cw_limit)
        else $error("steps after cw limit");
    property p_ccw_limit;
        $rose(ccwLimitIn) && posMove |-> ##8 (!stepPulse) [*8];
    endproperty
    a_ccw_limit: assert property (p_ccw_limit)
        else $error("steps after ccw limit");
    property p_spacing;
        stepPulse |=> (!stepPulse) [*8];
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("step rate too high");
    property p_dir;
        stepPulse && dirMove |-> stepDir == startDir;
    endproperty
    a_dir: assert property (p_dir)
        else $error("wrong step direction");
    property p_dir_hold;
        stepPulse |-> $stable(stepDir);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction changed at step");
endmodule

// ---- testbench/smp_host_model.sv ----
// Avalon-MM host model issuing register accesses
`timescale 1ns/100ps
module smp_host_model (
    input wire logic core_clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [5:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata
);
    int timeouts = 0;
    initial begin
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
    end
    // One bus cycle: hold the request until waitrequest is seen low
    task automatic access(input logic rw, input logic [5:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        read <= !rw;
        write <= rw;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        if (waitrequest !== 1'b0) timeouts++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        address <= ~a;
        writedata <= ~d;
    endtask
endmodule

// ---- testbench/smp_move_profiler_tb_top.sv ----
// Self-checking bench for the stepper move profiler
`timescale 1ns/100ps
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module smp_move_profiler_tb_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic stopJogIn = 1'b0;
    logic cwLimitIn = 1'b0;
    logic ccwLimitIn = 1'b0;
    logic estopIn = 1'b0;
    logic [5:0] address;
    logic read, write, waitrequest, stepPulse, stepDir, motorPower;
    logic [31:0] writedata, readdata, q;
    int n_errors = 0;
    int samples_checked = 0;
    int posModel = 0;
    smp_move_profiler #(.TICK_CYC(20)) i_smp_move_profiler (.core_clk,
        .resetn, .clkEn(1'b1), .address, .read, .write, .writedata,
        .readdata, .waitrequest, .stopJogIn, .cwLimitIn, .ccwLimitIn,
        .estopIn, .stepPulse, .stepDir, .motorPower);
    smp_host_model i_smp_host_model (.core_clk, .waitrequest, .readdata,
        .address, .read, .write, .writedata);
    initial forever #25 core_clk = ~core_clk;
    // Position seen at the step pins
    always @(posedge core_clk) begin
        if (stepPulse === 1'b1) posModel <= posModel + (stepDir ? 1 : -1);
    end
    task automatic finish_test();
        n_errors += i_smp_host_model.timeouts;
        $display("Counts: %0d errors, %0d checks", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_smp_host_model.access(1'b1, a, d, x);
        if (i_smp_host_model.timeouts != 0) finish_test();
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        i_smp_host_model.access(1'b0, a, 32'h00000000, d);
        if (i_smp_host_model.timeouts != 0) finish_test();
    endtask
    task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
        rd(a, q);
        `CHK(q, e)
    endtask
    task automatic chk_bit(input int b, input logic v);
        rd(smp_pkg::A_STATUS, q);
        `CHK(q[b], v)
    endtask
    task automatic go(input logic [2:0] ty, input logic [23:0] tgt);
        wr(smp_pkg::A_TARGET, {8'h00, tgt});
        wr(smp_pkg::A_CTRL, {21'h000000, ty, 8'h01});
    endtask
    task automatic wait_stat(input int b, input logic v);
        int n;
        for (n = 0; n < 10000; n++) begin
            rd(smp_pkg::A_STATUS, q);
            if (q[b] === v) break;
        end
        if (n == 10000) begin
            n_errors++;
            $display("ERROR %0t: status wait timed out", $time);
            finish_test();
        end
    endtask
    task automatic wait_steps(input int k);
        int p0;
        int n;
        p0 = posModel;
        for (n = 0; n < 20000; n++) begin
            @(posedge core_clk);
            if (posModel - p0 == k || p0 - posModel == k) break;
        end
        if (n == 20000) begin
            n_errors++;
            $display("ERROR %0t: step wait timed out", $time);
            finish_test();
        end
    endtask
    task automatic cfg(input logic [12:0] jk);
        wr(smp_pkg::A_SPEED, 32'h00061A80);
        wr(smp_pkg::A_START, 32'h000186A0);
        wr(smp_pkg::A_ACCEL, 32'h000003E8);
        wr(smp_pkg::A_DECEL, 32'h000001F4);
        wr(smp_pkg::A_JERK, {19'h00000, jk});
    endtask
    initial begin
        logic [12:0] jk[4];
        int tm[4];
        int t0;
        jk = '{13'h0000, 13'h0001, 13'h0002, 13'h1388};
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        chk_rd(smp_pkg::A_STATUS, 32'h00000000);
        chk_rd(6'h3C, 32'h00000000);
        `CHK(motorPower, 1'b1)
        wr(smp_pkg::A_CTRL, 32'h00000004);
        chk_bit(smp_pkg::S_HOLD, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cfg(jk[i]);
            t0 = int'($time);
            go(smp_pkg::MV_REL, 24'h000028);
            wait_stat(smp_pkg::S_BUSY, 1'b0);
            tm[i] = int'($time) - t0;
            chk_rd(smp_pkg::A_POS, 32'h28 * (i + 1));
            `CHK(posModel, 40 * (i + 1))
        end
        `CHK(tm[1] > tm[0], 1'b1)
        `CHK(tm[2] > tm[3], 1'b1)
        cfg(13'h0000);
        go(smp_pkg::MV_REL, 24'hFFFFEB);
        wait_stat(smp_pkg::S_BUSY, 1'b0);
        chk_rd(smp_pkg::A_POS, 32'h0000008B);
        $display("Test done: ramp shapes");
        go(smp_pkg::MV_REL, 24'h800000);
        chk_bit(smp_pkg::S_PERR, 1'b1);
        wr(smp_pkg::A_CTRL, 32'h00000010);
        wr(smp_pkg::A_START, 32'h00000000);
        go(smp_pkg::MV_REL, 24'h00000A);
        chk_bit(smp_pkg::S_PERR, 1'b1);
        cfg(13'h0000);
        wr(smp_pkg::A_CTRL, 32'h00000010);
        chk_bit(smp_pkg::S_PERR, 1'b0);
        `CHK(posModel, 139)
        $display("Test done: refused profiles");
        go(smp_pkg::MV_REL, 24'h000078);
        wait_steps(5);
        wr(smp_pkg::A_CTRL, 32'h00000004);
        wait_stat(smp_pkg::S_HOLD, 1'b1);
        wr(smp_pkg::A_TARGET, 32'h00000005);
        wr(smp_pkg::A_SPEED, 32'h00030D40);
        wr(smp_pkg::A_CTRL, 32'h00000008);
        wait_steps(2);
        stopJogIn <= 1'b1;
        wait_stat(smp_pkg::S_BUSY, 1'b0);
        stopJogIn <= 1'b0;
        chk_rd(smp_pkg::A_POS, 32'h00000103);
        wr(smp_pkg::A_TARGET, 32'h00000001);
        wr(smp_pkg::A_CTRL, {21'h000000, smp_pkg::MV_JOG, 8'h21});
        wait_steps(5);
        stopJogIn <= 1'b1;
        wait_stat(smp_pkg::S_BUSY, 1'b0);
        stopJogIn <= 1'b0;
        chk_bit(smp_pkg::S_PINV, 1'b0);
        chk_rd(smp_pkg::A_POS, posModel);
        $display("Test done: hold and stop-jog");
        go(smp_pkg::MV_REL, 24'h0007D0);
        wait_steps(4);
        wr(smp_pkg::A_CTRL, 32'h00000002);
        wr(smp_pkg::A_CTRL, 32'h00000008);
        chk_bit(smp_pkg::S_BUSY, 1'b0);
        chk_bit(smp_pkg::S_PINV, 1'b1);
        chk_rd(smp_pkg::A_POS, posModel);
        t0 = posModel;
        go(smp_pkg::MV_REL, 24'h00000A);
        wait_stat(smp_pkg::S_BUSY, 1'b0);
        chk_rd(smp_pkg::A_POS, t0 + 10);
        go(smp_pkg::MV_ABS, 24'h000000);
        chk_bit(smp_pkg::S_PERR, 1'b1);
        wr(smp_pkg::A_CTRL, 32'h00000010);
        wr(smp_pkg::A_POS, 32'h00000000);
        posModel = 0;
        chk_bit(smp_pkg::S_PINV, 1'b0);
        go(smp_pkg::MV_REL, 24'h0007D0);
        wait_steps(3);
        estopIn <= 1'b1;
        repeat (20) @(posedge core_clk);
        estopIn <= 1'b0;
        chk_bit(smp_pkg::S_BUSY, 1'b0);
        chk_bit(smp_pkg::S_PINV, 1'b1);
        `CHK(motorPower, 1'b1)
        $display("Test done: immediate stops");
        go(smp_pkg::MV_REL, 24'h0007D0);
        wait_steps(3);
        cwLimitIn <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk_bit(smp_pkg::S_FCW, 1'b1);
        chk_bit(smp_pkg::S_BUSY, 1'b0);
        t0 = posModel;
        go(smp_pkg::MV_REL, 24'hFFFFF6);
        wait_stat(smp_pkg::S_BUSY, 1'b0);
        chk_rd(smp_pkg::A_POS, t0 - 10);
        go(smp_pkg::MV_REL, 24'h00000A);
        chk_bit(smp_pkg::S_PERR, 1'b1);
        cwLimitIn <= 1'b0;
        wr(smp_pkg::A_CTRL, 32'h00000010);
        go(smp_pkg::MV_REL, 24'h0007D0);
        wait_steps(3);
        ccwLimitIn <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk_bit(smp_pkg::S_FCCW, 1'b0);
        chk_bit(smp_pkg::S_BUSY, 1'b0);
        $display("Test done: limits");
        finish_test();
    end
endmodule
bind smp_move_profiler smp_move_checker i_smp_move_checker (.core_clk,
    .resetn, .address, .write, .writedata, .cwLimitIn, .ccwLimitIn,
    .estopIn, .stepPulse, .stepDir, .motorPower);
